// ### core/dsml_defs.svh
/*
 Constants of the switch-mode logic: serial frame layout, address map,
 mode codes and reset values. Assumes inclusion by bare name.
*/
`ifndef DSML_DEFS_SVH
`define DSML_DEFS_SVH
// Serial frame: 8 command bits then 16 data bits
`define DSML_CMD_LAST   5'h07
`define DSML_FRAME_LAST 5'h17
`define DSML_FRAME_DONE 5'h18
// Command byte: bit 7 write, bits 5:0 address
`define DSML_CMD_WR_BIT 7
// Address map
`define DSML_NV_WORDS   61
`define DSML_ADDR_INIT  6'h3d
`define DSML_ADDR_MODE  6'h3e
`define DSML_ADDR_RB    6'h3f
// Mode codes of the one-sided and buffer modes
`define DSML_M_A0_BZ    4'h4
`define DSML_M_A_FOLLOW 4'h5
`define DSML_M_A_INV    4'h6
`define DSML_M_A1_BZ    4'h7
`define DSML_M_AZ_B0    4'h8
`define DSML_M_B_FOLLOW 4'h9
`define DSML_M_B_INV    4'ha
`define DSML_M_AZ_B1    4'hb
// Reset values
`define DSML_MODE_RST   16'h0000
`define DSML_OEN_RST    8'hff
`endif

// ### core/dsml_pkg.sv
/*
 Types of the switch-mode logic.
 Assumes nothing of its surroundings.
*/
package dsml_pkg;
    // Boot copies the initial setting, run lets the switches act
    typedef enum logic {
        PH_BOOT,
        PH_RUN
    } dsml_phase_t;
endpackage

// ### core/dsml_switch_core.sv
/*
 Switch-mode logic: serial slave, general nonvolatile words, initial
 setting word, volatile mode register, four two-pin switches, readback.
 Assumes a host drives sel/sclk/sdi slowly against clk (each sclk level
 lasts at least three clk cycles); pins resolved by the testbench.
*/
`timescale 1ns/100ps
`include "dsml_defs.svh"

// Notes on behaviour
// - Four switches, two pins each, set separately.
// - Four code bits pick one of fourteen modes.
// - Mode register is sixteen bits, all switches.
// - Mode register volatile, written instantly, no wear.
// - Power-up copies initial setting into mode register.
// - Codes 0-3: A drives bit1, B drives bit0.
// - Code 4 A=0, code 7 A=1; B floats.
// - Code 8 B=0, code 11 B=1; A floats.
// - Codes 5,6,9,10 buffer or invert between pins.
// - Codes 12/13 analog open, 14/15 closed; bit0 ignored.
// - Readback register samples pin levels.
// - Closed analog pins read invalid; others work.
// - Processor reaches registers via four-wire serial (sel, sclk, sdi, sdo).
// - Sixty-one general sixteen-bit nonvolatile words.
module dsml_switch_core (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sel,        // Serial select, high active
    input  wire logic        sclk,       // Serial clock from host
    input  wire logic        sdi,        // Serial data in
    output logic             sdo,        // Serial data out
    input  wire logic [7:0]  pin_in,     // Pin levels, 2i=A 2i+1=B
    output logic      [7:0]  pin_out,    // Pin drive values
    output logic      [7:0]  pin_oe_n,   // Low while a pin is driven
    output logic      [3:0]  ana_close   // Analog path closed per switch
);
    // Pin and serial synchronisers
    logic [7:0]  pin_m;                  // First stage, read only by pin_s
    logic [7:0]  pin_s;                  // Synchronised pins
    logic [2:0]  ser_m;                  // First stage of sel/sclk/sdi
    logic [2:0]  ser_s;                  // Synchronised sel/sclk/sdi
    logic        sclk_d;                 // Previous sclk for edges
    // Serial frame state
    logic [4:0]  cnt;                    // Bits taken in this frame
    logic [15:0] shin;                   // Input shift register
    logic [15:0] shout;                  // Output shift register
    logic [7:0]  cmd;                    // Captured command byte
    logic [4:0]  next_cnt;
    logic [15:0] next_shin;
    logic [15:0] next_shout;
    logic [7:0]  next_cmd;
    // Storage
    logic [15:0] nv_mem [0:`DSML_NV_WORDS-1];  // General words
    logic [15:0] init_set;               // Initial switch setting word
    logic [15:0] mode;                   // Volatile mode register
    logic [15:0] next_mode;
    logic [15:0] rb;                     // Readback register
    logic [15:0] next_rb;
    dsml_pkg::dsml_phase_t phase;        // Boot or run
    dsml_pkg::dsml_phase_t next_phase;
    // Decoded serial events
    logic        rise;                   // Synchronised sclk rising
    logic        cmd_done;               // Command byte complete
    logic        wr_go;                  // Write word complete
    logic [15:0] wr_data;                // Word being written
    logic [5:0]  rd_addr;                // Address of the new command
    logic [15:0] rd_word;                // Word to shift out
    // Per-switch next pin values
    logic [7:0]  next_out;
    logic [7:0]  next_oe_n;
    logic [3:0]  next_close;

    // Two flops on every outside input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_m  <= 8'h00;
            pin_s  <= 8'h00;
            ser_m  <= 3'h0;
            ser_s  <= 3'h0;
            sclk_d <= 1'b0;
        end else begin
            pin_m  <= pin_in;
            pin_s  <= pin_m;
            ser_m  <= {sel, sclk, sdi};
            ser_s  <= ser_m;
            sclk_d <= ser_s[1];
        end
    end

    // Serial event decode, shifting on sclk rising
    assign rise     = ser_s[2] && ser_s[1] && !sclk_d;
    assign cmd_done = rise && (cnt == `DSML_CMD_LAST);
    assign rd_addr  = {shin[4:0], ser_s[0]};
    assign wr_data  = {shin[14:0], ser_s[0]};
    assign wr_go    = rise && (cnt == `DSML_FRAME_LAST)
                      && cmd[`DSML_CMD_WR_BIT];

    // Read mux over the address map
    always_comb begin
        if (rd_addr < 6'(`DSML_NV_WORDS)) begin
            rd_word = nv_mem[rd_addr];
        end else if (rd_addr == `DSML_ADDR_INIT) begin
            rd_word = init_set;
        end else if (rd_addr == `DSML_ADDR_MODE) begin
            rd_word = mode;
        end else begin
            rd_word = rb;
        end
    end

    // Serial slave next state: frames end when sel drops
    always_comb begin
        next_cnt   = cnt;
        next_shin  = shin;
        next_shout = shout;
        next_cmd   = cmd;
        if (!ser_s[2]) begin
            next_cnt = 5'h00;
        end else if (rise) begin
            next_shin  = wr_data;
            next_shout = {shout[14:0], 1'b0};
            if (cnt != `DSML_FRAME_DONE) begin
                next_cnt = cnt + 5'h01;
            end
            if (cmd_done) begin
                next_cmd   = {shin[6:0], ser_s[0]};
                next_shout = rd_word;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt   <= 5'h00;
            shin  <= 16'h0000;
            shout <= 16'h0000;
            cmd   <= 8'h00;
            sdo   <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            shin  <= next_shin;
            shout <= next_shout;
            cmd   <= next_cmd;
            sdo   <= next_shout[15];
        end
    end

    // Nonvolatile words: no reset, they survive rst like EEPROM cells
    always_ff @(posedge clk) begin
        if (wr_go && cmd[5:0] < 6'(`DSML_NV_WORDS)) begin
            nv_mem[cmd[5:0]] <= wr_data;
        end
        if (wr_go && cmd[5:0] == `DSML_ADDR_INIT) begin
            init_set <= wr_data;
        end
    end

    // Mode register: boot copy, then instant serial writes
    always_comb begin
        next_mode  = mode;
        next_phase = dsml_pkg::PH_RUN;
        unique case (phase)
            dsml_pkg::PH_BOOT: begin
                next_mode = init_set;
            end
            dsml_pkg::PH_RUN: begin
                if (wr_go && cmd[5:0] == `DSML_ADDR_MODE) begin
                    next_mode = wr_data;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode  <= `DSML_MODE_RST;
            phase <= dsml_pkg::PH_BOOT;
        end else begin
            mode  <= next_mode;
            phase <= next_phase;
        end
    end

    // Per-switch mode decode; nibble i, A=pin 2i, B=pin 2i+1
    for (genvar i = 0; i < 4; i++) begin : g_sw
        logic [3:0] c;                                // Nibble of switch i
        logic       a_in;
        logic       b_in;
        assign c    = mode[4*i +: 4];
        assign a_in = pin_s[2*i];
        assign b_in = pin_s[2*i+1];
        always_comb begin
            next_out[2*i]    = 1'b0;
            next_out[2*i+1]  = 1'b0;
            next_oe_n[2*i]   = 1'b1;
            next_oe_n[2*i+1] = 1'b1;
            next_close[i]    = 1'b0;
            // Held floating until the boot copy is in place
            if (phase == dsml_pkg::PH_RUN) begin
                unique case (c[3:2])
                    2'h0: begin
                        next_out[2*i]    = c[1];
                        next_out[2*i+1]  = c[0];
                        next_oe_n[2*i]   = 1'b0;
                        next_oe_n[2*i+1] = 1'b0;
                    end
                    2'h1: begin
                        next_oe_n[2*i] = 1'b0;
                        unique case (c)
                            `DSML_M_A0_BZ:    next_out[2*i] = 1'b0;
                            `DSML_M_A_FOLLOW: next_out[2*i] = b_in;
                            `DSML_M_A_INV:    next_out[2*i] = !b_in;
                            default:          next_out[2*i] = 1'b1;
                        endcase
                    end
                    2'h2: begin
                        next_oe_n[2*i+1] = 1'b0;
                        unique case (c)
                            `DSML_M_AZ_B0:    next_out[2*i+1] = 1'b0;
                            `DSML_M_B_FOLLOW: next_out[2*i+1] = a_in;
                            `DSML_M_B_INV:    next_out[2*i+1] = !a_in;
                            default:          next_out[2*i+1] = 1'b1;
                        endcase
                    end
                    2'h3: begin
                        next_close[i] = c[1];
                    end
                endcase
            end
            // Closed analog pins are not valid inputs
            next_rb[2*i +: 2] = next_close[i] ? 2'h0 : pin_s[2*i +: 2];
        end
    end
    assign next_rb[15:8] = 8'h00;

    // Pin drivers and readback, registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out   <= 8'h00;
            pin_oe_n  <= `DSML_OEN_RST;
            ana_close <= 4'h0;
            rb        <= 16'h0000;
        end else begin
            pin_out   <= next_out;
            pin_oe_n  <= next_oe_n;
            ana_close <= next_close;
            rb        <= next_rb;
        end
    end

    // Checks on the switches and the register paths
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_boot_copy: assert property (phase == dsml_pkg::PH_BOOT |=> mode === $past(init_set))
        else $error("boot copy missed");
    a_drive_mode: assert property (phase == dsml_pkg::PH_RUN && mode[3:2] == 2'h0
        |=> pin_out[1:0] == {$past(mode[0]), $past(mode[1])} && pin_oe_n[1:0] == 2'h0)
        else $error("drive mode wrong");
    a_one_side_a: assert property (phase == dsml_pkg::PH_RUN && mode[7:4] == 4'h7
        |=> pin_out[2] && !pin_oe_n[2] && pin_oe_n[3])
        else $error("code 7 wrong");
    a_one_side_b: assert property (phase == dsml_pkg::PH_RUN && mode[11:8] == 4'h8
        |=> !pin_out[5] && pin_oe_n[4] && !pin_oe_n[5])
        else $error("code 8 wrong");
    a_buf_follow: assert property (phase == dsml_pkg::PH_RUN && mode[3:0] == 4'h5
        |=> pin_out[0] == $past(pin_s[1]))
        else $error("follow wrong");
    a_buf_inv: assert property (phase == dsml_pkg::PH_RUN && mode[15:12] == 4'ha
        |=> pin_out[7] == !$past(pin_s[6]))
        else $error("invert wrong");
    a_analog_ctl: assert property (phase == dsml_pkg::PH_RUN && mode[3:2] == 2'h3
        |=> ana_close[0] == $past(mode[1]) && pin_oe_n[1:0] == 2'h3)
        else $error("analog wrong");
    a_rb_mask: assert property (ana_close[0] |-> rb[1:0] == 2'h0)
        else $error("closed pins read");
    a_mode_write: assert property (phase == dsml_pkg::PH_RUN && wr_go
        && cmd[5:0] == `DSML_ADDR_MODE
        |=> mode == $past(wr_data) ##1 (mode[3:2] != 2'h0
            || (pin_oe_n[1:0] == 2'h0 && pin_out[1:0] == {mode[0], mode[1]})))
        else $error("mode write lost");
    a_init_keep: assert property (wr_go && cmd[5:0] == `DSML_ADDR_MODE
        |=> init_set == $past(init_set))
        else $error("initial setting changed");

    c_mode_write: cover property (wr_go && cmd[5:0] == `DSML_ADDR_MODE);
    c_read_frame: cover property (cmd_done && !shin[6] ##[1:300] cnt == `DSML_FRAME_DONE);
    c_analog_mix: cover property (ana_close[2] && pin_oe_n[2] == 1'b0);
endmodule // dsml_switch_core

// ### dv/dip_switch_mode_logic_tb_top.sv
/*
 Testbench of the switch-mode logic: scenarios as tasks, host model on
 the serial port. Assumes undriven pins settle to the level in ext.
*/
`timescale 1ns/100ps
module dip_switch_mode_logic_tb_top;
    logic        clk;          // 40 MHz clock
    logic        rst;          // Power-up reset
    logic        sel;          // Serial select
    logic        sclk;         // Serial clock
    logic        sdi;          // Serial data in
    logic        sdo;          // Serial data out
    logic [7:0]  ext;          // Level outside circuitry puts on free pins
    logic [7:0]  pin_out;      // Drive values
    logic [7:0]  pin_oe_n;     // Low while driven
    logic [3:0]  ana_close;    // Analog paths
    logic [7:0]  pin_lvl;      // Resolved pin levels
    logic [15:0] rv;           // Last read word
    int          failures;     // Mismatches
    int          total_checks; // Comparisons

    // Driven pins win over the outside level
    assign pin_lvl = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    dsml_switch_core uut (.clk(clk), .rst(rst), .sel(sel), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .pin_in(pin_lvl), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .ana_close(ana_close));
    dsml_host_model host (.clk(clk), .sel(sel), .sclk(sclk), .sdi(sdi),
        .sdo(sdo));

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] unused;
        host.frame({2'b10, a}, d, unused);
    endtask

    task automatic rd(input logic [5:0] a);
        host.frame({2'b00, a}, 16'h0000, rv);
    endtask

    // Let pin updates and the buffer sync path land
    task automatic settle;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic print_verdict;
        $display("Checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Word store, boundary words, initial setting kept apart
    task automatic t_regs;
        wr(6'h00, 16'h5a3c);
        wr(6'h3c, 16'hc3a5);
        wr(6'h3d, 16'h0123);
        wr(6'h3e, 16'hffff);
        rd(6'h00); check("nv word 0", rv, 16'h5a3c);
        rd(6'h3c); check("nv word 60", rv, 16'hc3a5);
        rd(6'h3d); check("initial kept", rv, 16'h0123);
        rd(6'h3e); check("mode word", rv, 16'hffff);
        $display("Done t_regs");
    endtask

    // Power-up copies the initial setting into the mode register
    task automatic t_powerup;
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("oe in reset", {8'h00, pin_oe_n}, 16'h00ff);
        rst = 1'b0;
        settle();
        check("boot out", {8'h00, pin_out}, 16'h0027);
        check("boot oe", {8'h00, pin_oe_n}, 16'h0000);
        rd(6'h3e); check("boot mode", rv, 16'h0123);
        $display("Done t_powerup");
    endtask

    // Codes 0 to 3, one per switch
    task automatic t_drive;
        wr(6'h3e, 16'h0321);
        @(posedge clk);
        #1 check("drive next clk", {8'h00, pin_out}, 16'h0036);
        settle();
        check("drive out", {8'h00, pin_out}, 16'h0036);
        check("drive oe", {8'h00, pin_oe_n}, 16'h0000);
        $display("Done t_drive");
    endtask

    // Codes 4, 7, 8, 11: one pin driven, its mate floats
    task automatic t_onesided;
        wr(6'h3e, 16'hb874);
        settle();
        check("side oe", {8'h00, pin_oe_n}, 16'h005a);
        check("side out", {8'h00, pin_out & 8'ha5}, 16'h0084);
        $display("Done t_onesided");
    endtask

    // Codes 5, 6, 9, 10 follow or invert the mate pin
    task automatic t_buffer;
        logic [7:0] pats [2];
        logic [7:0] e;
        pats = '{8'h5a, 8'ha5};
        wr(6'h3e, 16'ha965);
        foreach (pats[k]) begin
            ext = pats[k];
            settle();
            e = {~ext[6], 1'b0, ext[4], 2'b00, ~ext[3], 1'b0, ext[1]};
            check("buffer out", {8'h00, pin_out & 8'ha5}, {8'h00, e});
            check("buffer oe", {8'h00, pin_oe_n}, 16'h005a);
        end
        ext = 8'hff;
        $display("Done t_buffer");
    endtask

    // Analog open/closed, bit0 ignored, readback beside closed pins
    task automatic t_analog;
        wr(6'h3e, 16'hfedc);
        settle();
        check("analog close", {12'h000, ana_close}, 16'h000c);
        check("analog oe", {8'h00, pin_oe_n}, 16'h00ff);
        wr(6'h3e, 16'h3e0c);
        wr(6'h3f, 16'hffff);
        settle();
        check("mixed close", {12'h000, ana_close}, 16'h0004);
        rd(6'h3f); check("readback", rv, 16'h00c3);
        rd(6'h3e); check("readback wr", rv, 16'h3e0c);
        $display("Done t_analog");
    endtask

    // Hang guard: counts as a mismatch
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        failures     = 0;
        total_checks = 0;
        rst          = 1'b1;
        ext          = 8'hff;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        settle();
        t_regs();
        t_powerup();
        t_drive();
        t_onesided();
        t_buffer();
        t_analog();
        print_verdict();
    end
endmodule // dip_switch_mode_logic_tb_top

// ### dv/dsml_host_model.sv
/*
 Host processor model: sends serial frames into the switch logic.
 Assumes the same clk as the device; every sclk level lasts 4 clk.
*/
`timescale 1ns/100ps
module dsml_host_model (
    input  wire logic clk,  // System clock
    output logic      sel,  // Frame select
    output logic      sclk, // Serial clock, still outside frames
    output logic      sdi,  // Serial data to device
    input  wire logic sdo   // Serial data from device
);
    initial begin
        sel  = 1'b0;
        sclk = 1'b0;
        sdi  = 1'b0;
    end

    // One frame: command byte then 16 data bits, MSB first
    task automatic frame(input logic [7:0] cmd, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [23:0] bits;
        bits = {cmd, wd};
        rd   = 16'h0000;
        @(posedge clk);
        #1 sel = 1'b1;
        for (int i = 23; i >= 0; i--) begin
            sdi = bits[i];
            repeat (4) @(posedge clk);
            // Sample just before the rise, where the bit has settled
            #1 if (i < 16) rd[i] = sdo;
            sclk = 1'b1;
            repeat (4) @(posedge clk);
            #1 sclk = 1'b0;
        end
        repeat (4) @(posedge clk);
        // Released data line flips, so a stale bit cannot pass as valid
        #1 sel = 1'b0;
        sdi = ~sdi;
        repeat (6) @(posedge clk);
    endtask
endmodule // dsml_host_model
